//--- hw/usb_regs_pkg.sv
package usb_regs_pkg;

    // bus geometry
    localparam int ADDR_W = 12;
    localparam int NUM_EP = 8;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // register byte offsets
    localparam logic [11:0] OFF_IRQ_MASK = 12'h010;
    localparam logic [11:0] OFF_IRQ_EN_CLR = 12'h014;
    localparam logic [11:0] OFF_IRQ_EN_SET = 12'h018;
    localparam logic [11:0] OFF_EP_ENABLE = 12'h01c;
    localparam logic [11:0] OFF_FRAME_NUMBER = 12'h020;
    localparam logic [11:0] OFF_EP_CONFIG = 12'h100;
    localparam logic [11:0] OFF_EP_CONFIG_LAST = 12'h11c;

    // interrupt enable mask layout
    localparam int MASK_SUSPEND_BIT = 0;
    localparam int MASK_SOF_BIT = 2;
    localparam int MASK_END_RESET_BIT = 3;
    localparam int MASK_WAKEUP_BIT = 4;
    localparam int MASK_END_RESUME_BIT = 5;
    localparam int MASK_UP_RESUME_BIT = 6;
    localparam int MASK_EP_LSB = 12;
    localparam logic [31:0] MASK_DEFINED = 32'h000f_f07d;
    localparam logic [31:0] MASK_RESET = 32'h0000_0000;
    localparam logic [7:0] EP_ENABLE_RESET = 8'h00;

    // frame number register layout
    localparam int FRAME_COUNT_FIELD_LSB = 3;
    localparam int FRAME_COUNT_FIELD_W = 11;
    localparam int FRAME_CRC_ERROR_FLAG_BIT = 15;

    // endpoint configuration layout
    localparam int REDIR_LSB = 16;
    localparam int KIND_LSB = 11;
    localparam int DIR_BIT = 8;
    localparam int SIZE_LSB = 4;
    localparam int BANK_BIT = 2;

    typedef enum logic [1:0] {
        KIND_CONTROL = 2'b00,
        KIND_ISOCHRONOUS = 2'b01,
        KIND_BULK = 2'b10,
        KIND_INTERRUPT = 2'b11
    } ep_kind_t;

    typedef struct packed {
        logic [3:0] redirect_ep_number;
        ep_kind_t endpoint_kind;
        logic endpoint_direction;
        logic [2:0] endpoint_bank_size;
        logic endpoint_bank_count;
    } ep_cfg_t;

    localparam ep_cfg_t CFG_RESET = '0;

    // one start-of-frame report
    typedef struct packed {
        logic valid;
        logic crc_err;
        logic [10:0] frame;
    } sof_in_t;

    // one register write from the bus port
    typedef struct packed {
        logic en;
        logic [11:0] addr;
        logic [31:0] data;
        logic [3:0] strb;
    } reg_wr_t;

    // expand byte strobes into a bit mask
    function automatic logic [31:0] strb_bits(input logic [3:0] strb);
        logic [31:0] m;
        m = '0;
        for (int i = 0; i < 4; i++) begin
            m[i*8 +: 8] = {8{strb[i]}};
        end
        return m;
    endfunction

    // merge new data under byte strobes
    function automatic logic [31:0] strb_merge(input logic [31:0] old_w,
                                               input logic [31:0] new_w,
                                               input logic [3:0] strb);
        return (old_w & ~strb_bits(strb)) | (new_w & strb_bits(strb));
    endfunction

    // configuration record as a word
    function automatic logic [31:0] cfg_to_word(input ep_cfg_t c);
        logic [31:0] w;
        w = '0;
        w[REDIR_LSB +: 4] = c.redirect_ep_number;
        w[KIND_LSB +: 2] = c.endpoint_kind;
        w[DIR_BIT] = c.endpoint_direction;
        w[SIZE_LSB +: 3] = c.endpoint_bank_size;
        w[BANK_BIT] = c.endpoint_bank_count;
        return w;
    endfunction

endpackage

//--- hw/axil_reg_port.sv
`timescale 1ns/1ns
module axil_reg_port (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic [usb_regs_pkg::ADDR_W-1:0] s_awaddr_i,
    input wire logic s_awvalid_i,
    output logic s_awready_o,
    input wire logic [31:0] s_wdata_i,
    input wire logic [3:0] s_wstrb_i,
    input wire logic s_wvalid_i,
    output logic s_wready_o,
    output logic [1:0] s_bresp_o,
    output logic s_bvalid_o,
    input wire logic s_bready_i,
    input wire logic [usb_regs_pkg::ADDR_W-1:0] s_araddr_i,
    input wire logic s_arvalid_i,
    output logic s_arready_o,
    output logic [31:0] s_rdata_o,
    output logic [1:0] s_rresp_o,
    output logic s_rvalid_o,
    input wire logic s_rready_i,
    output usb_regs_pkg::reg_wr_t wr_o,
    input wire logic wr_err_i,
    input wire logic [31:0] rd_data_i,
    input wire logic rd_err_i
);
    import usb_regs_pkg::*;

    typedef enum logic [2:0] {
        W_COLLECT = 3'b001,
        W_EXEC = 3'b010,
        W_RESP = 3'b100
    } wr_state_t;

    wr_state_t wr_state_r;
    logic aw_got_r;
    logic w_got_r;
    reg_wr_t req_r;

    assign s_awready_o = (wr_state_r == W_COLLECT) && !aw_got_r;
    assign s_wready_o = (wr_state_r == W_COLLECT) && !w_got_r;
    assign s_bvalid_o = (wr_state_r == W_RESP);
    assign s_arready_o = !s_rvalid_o;
    assign wr_o = '{en: (wr_state_r == W_EXEC), addr: req_r.addr,
                    data: req_r.data, strb: req_r.strb};

    // address and data in either order, executed once
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            wr_state_r <= W_COLLECT;
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            req_r <= '0;
            s_bresp_o <= RESP_OKAY;
        end else begin
            case (wr_state_r)
                W_COLLECT: begin
                    if (s_awvalid_i && s_awready_o) begin
                        aw_got_r <= 1'b1;
                        req_r.addr <= s_awaddr_i;
                    end
                    if (s_wvalid_i && s_wready_o) begin
                        w_got_r <= 1'b1;
                        req_r.data <= s_wdata_i;
                        req_r.strb <= s_wstrb_i;
                    end
                    if (aw_got_r && w_got_r) begin
                        wr_state_r <= W_EXEC;
                    end
                end
                W_EXEC: begin
                    s_bresp_o <= wr_err_i ? RESP_SLVERR : RESP_OKAY;
                    wr_state_r <= W_RESP;
                end
                W_RESP: begin
                    if (s_bready_i) begin
                        aw_got_r <= 1'b0;
                        w_got_r <= 1'b0;
                        wr_state_r <= W_COLLECT;
                    end
                end
                default: wr_state_r <= W_COLLECT;
            endcase
        end
    end

    // data sampled at the address edge; answer a cycle later
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            s_rvalid_o <= 1'b0;
            s_rdata_o <= '0;
            s_rresp_o <= RESP_OKAY;
        end else if (s_arvalid_i && s_arready_o) begin
            s_rvalid_o <= 1'b1;
            s_rdata_o <= rd_data_i;
            s_rresp_o <= rd_err_i ? RESP_SLVERR : RESP_OKAY;
        end else if (s_rready_i) begin
            s_rvalid_o <= 1'b0;
        end
    end

endmodule

//--- hw/ep_config_slot.sv
`timescale 1ns/1ns
module ep_config_slot #(
    parameter bit KEEP_LAYOUT_ON_BUS_RESET = 1'b0
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic wr_en_i,
    input wire logic [31:0] wr_data_i,
    input wire logic usb_reset_i,
    input wire logic disable_i,
    output usb_regs_pkg::ep_cfg_t cfg_o
);
    import usb_regs_pkg::*;

    // one endpoint's configuration record
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            cfg_o <= CFG_RESET;
        end else if (usb_reset_i) begin
            cfg_o.redirect_ep_number <= '0;
            cfg_o.endpoint_kind <= KIND_CONTROL;
            cfg_o.endpoint_direction <= 1'b0;
            if (!KEEP_LAYOUT_ON_BUS_RESET) begin
                cfg_o.endpoint_bank_size <= '0;
                cfg_o.endpoint_bank_count <= 1'b0;
            end
        end else if (wr_en_i) begin
            cfg_o.redirect_ep_number <= wr_data_i[REDIR_LSB +: 4];
            cfg_o.endpoint_kind <= ep_kind_t'(wr_data_i[KIND_LSB +: 2]);
            cfg_o.endpoint_direction <= wr_data_i[DIR_BIT];
            cfg_o.endpoint_bank_size <= wr_data_i[SIZE_LSB +: 3];
            cfg_o.endpoint_bank_count <= wr_data_i[BANK_BIT];
        end else if (disable_i) begin
            // disabling drops redirection, keeps layout and kind
            cfg_o.redirect_ep_number <= '0;
        end
    end

endmodule

//--- hw/usb_device_endpoint_config_regs.sv
// How it works
// - one in enable-clear clears mask bit
// - one in enable-set sets mask bit
// - zero bits leave the mask alone
// - endpoint enables from bit 12, events low
// - disabling ignores requests, resets endpoint state
// - setting enable bit enables, reads back state
// - enable register: bit n for endpoint n
// - bus reset clears the frame error flag
// - corrupted frame number sets error bit 15
// - error flag and frame event move together
// - bus reset clears frame, redirect, kind
// - frame field holds last 11-bit frame
// - frame loads even on a bad check
// - per-endpoint config word holds redirect number
// - kind: control, isochronous, bulk, interrupt
// - mask bit one enables, resets to zero
// - frame event raises interrupt only when enabled
//
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/1ns
module usb_device_endpoint_config_regs (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic [usb_regs_pkg::ADDR_W-1:0] s_awaddr_i,
    input wire logic s_awvalid_i,
    output logic s_awready_o,
    input wire logic [31:0] s_wdata_i,
    input wire logic [3:0] s_wstrb_i,
    input wire logic s_wvalid_i,
    output logic s_wready_o,
    output logic [1:0] s_bresp_o,
    output logic s_bvalid_o,
    input wire logic s_bready_i,
    input wire logic [usb_regs_pkg::ADDR_W-1:0] s_araddr_i,
    input wire logic s_arvalid_i,
    output logic s_arready_o,
    output logic [31:0] s_rdata_o,
    output logic [1:0] s_rresp_o,
    output logic s_rvalid_o,
    input wire logic s_rready_i,
    input wire logic usb_reset_i,
    input wire usb_regs_pkg::sof_in_t sof_i,
    input wire logic tok_valid_i,
    input wire logic [3:0] tok_ep_i,
    output logic tok_accept_o,
    output logic tok_ignored_o,
    output logic [31:0] irq_enable_mask_o,
    output logic [7:0] endpoint_enable_o,
    output logic [7:0] endpoint_flush_o,
    output logic sof_event_o,
    output logic sof_irq_o,
    output logic [10:0] frame_count_o,
    output logic frame_crc_error_o,
    output usb_regs_pkg::ep_cfg_t [7:0] endpoint_config_o
);
    import usb_regs_pkg::*;

    reg_wr_t wr;
    logic wr_err;
    logic [31:0] rd_data;
    logic rd_err;

    logic [31:0] irq_enable_mask_r;
    logic [7:0] endpoint_enable_r;
    logic [7:0] endpoint_flush_r;
    logic [10:0] frame_count_field_r;
    logic frame_crc_error_flag_r;
    logic sof_event_r;

    logic [31:0] wr_bits;
    logic [31:0] ep_enable_nxt;
    logic [7:0] cfg_wr_sel;

    // address inside the configuration array
    function automatic logic is_cfg_addr(input logic [11:0] a);
        return (a >= OFF_EP_CONFIG) && (a <= OFF_EP_CONFIG_LAST) && (a[1:0] == 2'b00);
    endfunction

    // endpoint index of a configuration word address
    function automatic logic [2:0] cfg_index(input logic [11:0] a);
        logic [11:0] d;
        d = a - OFF_EP_CONFIG;
        return d[4:2];
    endfunction

    // true for any word this block answers
    function automatic logic is_mapped(input logic [11:0] a);
        return (a == OFF_IRQ_MASK) || (a == OFF_IRQ_EN_CLR) || (a == OFF_IRQ_EN_SET)
            || (a == OFF_EP_ENABLE) || (a == OFF_FRAME_NUMBER) || is_cfg_addr(a);
    endfunction

    axil_reg_port u_port (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .s_awaddr_i(s_awaddr_i),
        .s_awvalid_i(s_awvalid_i),
        .s_awready_o(s_awready_o),
        .s_wdata_i(s_wdata_i),
        .s_wstrb_i(s_wstrb_i),
        .s_wvalid_i(s_wvalid_i),
        .s_wready_o(s_wready_o),
        .s_bresp_o(s_bresp_o),
        .s_bvalid_o(s_bvalid_o),
        .s_bready_i(s_bready_i),
        .s_araddr_i(s_araddr_i),
        .s_arvalid_i(s_arvalid_i),
        .s_arready_o(s_arready_o),
        .s_rdata_o(s_rdata_o),
        .s_rresp_o(s_rresp_o),
        .s_rvalid_o(s_rvalid_o),
        .s_rready_i(s_rready_i),
        .wr_o(wr),
        .wr_err_i(wr_err),
        .rd_data_i(rd_data),
        .rd_err_i(rd_err)
    );

    // read-only or unmapped words refuse writes
    assign wr_err = !is_mapped(wr.addr) || (wr.addr == OFF_IRQ_MASK)
        || (wr.addr == OFF_FRAME_NUMBER);

    // strobed lanes only carry ones into set and clear
    assign wr_bits = wr.data & strb_bits(wr.strb) & MASK_DEFINED;

    // interrupt enable mask, touched only via set and clear;
    // one write path, so the later write always wins
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            irq_enable_mask_r <= MASK_RESET;
        end else if (wr.en && wr.addr == OFF_IRQ_EN_CLR) begin
            irq_enable_mask_r <= irq_enable_mask_r & ~wr_bits;
        end else if (wr.en && wr.addr == OFF_IRQ_EN_SET) begin
            irq_enable_mask_r <= irq_enable_mask_r | wr_bits;
        end
    end

    // enable word with the strobed write merged
    assign ep_enable_nxt = strb_merge({24'h000000, endpoint_enable_r}, wr.data, wr.strb);

    // enable bits; read back as the live state
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            endpoint_enable_r <= EP_ENABLE_RESET;
        end else if (wr.en && wr.addr == OFF_EP_ENABLE) begin
            endpoint_enable_r <= ep_enable_nxt[7:0];
        end
    end

    // each zero written with byte strobe 0 set flushes, even a disabled endpoint,
    // so rewriting zero always forces a clean endpoint
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            endpoint_flush_r <= '0;
        end else if (wr.en && wr.addr == OFF_EP_ENABLE && wr.strb[0]) begin
            endpoint_flush_r <= ~wr.data[7:0];
        end else begin
            endpoint_flush_r <= '0;
        end
    end

    // frame number capture
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            frame_count_field_r <= '0;
        end else if (usb_reset_i) begin
            frame_count_field_r <= '0;
        end else if (sof_i.valid) begin
            frame_count_field_r <= sof_i.frame;
        end
    end

    // error flag follows each report's check, on the
    // frame event's edge, so the two never disagree
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            frame_crc_error_flag_r <= 1'b0;
        end else if (usb_reset_i) begin
            frame_crc_error_flag_r <= 1'b0;
        end else if (sof_i.valid) begin
            frame_crc_error_flag_r <= sof_i.crc_err;
        end
    end

    // frame event pulse for the outside flag logic
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            sof_event_r <= 1'b0;
        end else begin
            sof_event_r <= sof_i.valid && !usb_reset_i;
        end
    end

    // config write select, one bit per endpoint
    always_comb begin
        cfg_wr_sel = '0;
        if (wr.en && is_cfg_addr(wr.addr)) begin
            cfg_wr_sel[cfg_index(wr.addr)] = 1'b1;
        end
    end

    // endpoint 0 keeps its bank layout across a bus reset
    genvar g;
    generate
        for (g = 0; g < NUM_EP; g++) begin : g_ep
            logic [31:0] merged;
            assign merged = strb_merge(cfg_to_word(endpoint_config_o[g]), wr.data, wr.strb);
            ep_config_slot #(
                .KEEP_LAYOUT_ON_BUS_RESET(g == 0)
            ) u_slot (
                .clk_i(clk_i),
                .rst_b_i(rst_b_i),
                .wr_en_i(cfg_wr_sel[g]),
                .wr_data_i(merged),
                .usb_reset_i(usb_reset_i),
                .disable_i(endpoint_flush_r[g]),
                .cfg_o(endpoint_config_o[g])
            );
        end
    endgenerate

    // read mux; set and clear read zero, holes error
    always_comb begin
        rd_data = '0;
        rd_err = 1'b0;
        if (is_cfg_addr(s_araddr_i)) begin
            rd_data = cfg_to_word(endpoint_config_o[cfg_index(s_araddr_i)]);
        end else begin
            case (s_araddr_i)
                OFF_IRQ_MASK: rd_data = irq_enable_mask_r;
                OFF_IRQ_EN_CLR: rd_data = '0;
                OFF_IRQ_EN_SET: rd_data = '0;
                OFF_EP_ENABLE: rd_data = {24'h000000, endpoint_enable_r};
                OFF_FRAME_NUMBER: begin
                    rd_data[FRAME_COUNT_FIELD_LSB +: FRAME_COUNT_FIELD_W] = frame_count_field_r;
                    rd_data[FRAME_CRC_ERROR_FLAG_BIT] = frame_crc_error_flag_r;
                end
                default: rd_err = 1'b1;
            endcase
        end
    end

    // token gate: disabled or absent endpoints drop
    // requests before the engine sees them
    always_comb begin
        tok_accept_o = 1'b0;
        tok_ignored_o = 1'b0;
        if (tok_valid_i) begin
            if (!tok_ep_i[3] && endpoint_enable_r[tok_ep_i[2:0]]) begin
                tok_accept_o = 1'b1;
            end else begin
                tok_ignored_o = 1'b1;
            end
        end
    end

    // frame irq gated by its enable bit
    assign sof_irq_o = sof_event_r && irq_enable_mask_r[MASK_SOF_BIT];

    assign irq_enable_mask_o = irq_enable_mask_r;
    assign endpoint_enable_o = endpoint_enable_r;
    assign endpoint_flush_o = endpoint_flush_r;
    assign sof_event_o = sof_event_r;
    assign frame_count_o = frame_count_field_r;
    assign frame_crc_error_o = frame_crc_error_flag_r;

endmodule

//--- testbench/usb_regs_chk.sv
`timescale 1ns/1ns
module usb_regs_chk
    import usb_regs_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic s_bvalid_o,
    input wire logic usb_reset_i,
    input wire usb_regs_pkg::sof_in_t sof_i,
    input wire logic tok_valid_i,
    input wire logic [3:0] tok_ep_i,
    input wire logic tok_accept_o,
    input wire logic tok_ignored_o,
    input wire logic [31:0] irq_enable_mask_o,
    input wire logic [7:0] endpoint_enable_o,
    input wire logic [7:0] endpoint_flush_o,
    input wire logic sof_event_o,
    input wire logic sof_irq_o,
    input wire logic [10:0] frame_count_o,
    input wire logic frame_crc_error_o,
    input wire usb_regs_pkg::ep_cfg_t [7:0] endpoint_config_o
);
    logic hit;
    logic dirty;
    // enabled endpoint below eight
    assign hit = (tok_ep_i < 4'h8) && endpoint_enable_o[tok_ep_i[2:0]];
    // fields a bus reset must wipe
    always_comb begin
        dirty = 1'b0;
        for (int i = 0; i < NUM_EP; i++) begin
            dirty = dirty | (|endpoint_config_o[i].redirect_ep_number);
            dirty = dirty | (|endpoint_config_o[i].endpoint_kind);
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    sequence sof_take;
        sof_i.valid && !usb_reset_i;
    endsequence
    sequence frame_shown;
        sof_event_o && frame_count_o == $past(sof_i.frame);
    endsequence
    a_sof_frame: assert property (sof_take |=> frame_shown)
        else $error("frame count not loaded");
    a_sof_crc_flag: assert property (sof_take |=> sof_event_o &&
        frame_crc_error_o == $past(sof_i.crc_err)) else $error("frame error flag wrong");
    a_bus_reset_frame: assert property (usb_reset_i |=>
        frame_count_o == 11'h000 && !frame_crc_error_o) else $error("bus reset left frame");
    a_bus_reset_cfg: assert property (usb_reset_i |=> !dirty)
        else $error("bus reset left config");
    a_sof_irq_gate: assert property (sof_irq_o ==
        (sof_event_o && irq_enable_mask_o[MASK_SOF_BIT])) else $error("frame irq gating wrong");
    a_tok_route: assert property (tok_valid_i |-> tok_accept_o == hit &&
        tok_ignored_o == !hit) else $error("token routing wrong");
    a_mask_defined: assert property ((irq_enable_mask_o & ~MASK_DEFINED) == 32'h0)
        else $error("undefined mask bit set");
    a_flush_pulse: assert property (|endpoint_flush_o |->
        (endpoint_flush_o & endpoint_enable_o) == 8'h00 ##1 endpoint_flush_o == 8'h00)
        else $error("flush pulse wrong");
    a_mask_on_write: assert property ($changed(irq_enable_mask_o) |-> $rose(s_bvalid_o))
        else $error("mask moved without a write");
endmodule
bind usb_device_endpoint_config_regs usb_regs_chk chk (.*);

//--- testbench/usb_host_model.sv
`timescale 1ns/1ns
module usb_host_model
    import usb_regs_pkg::*;
(
    input wire logic clk_i,
    output usb_regs_pkg::sof_in_t sof_o,
    output logic usb_reset_o,
    output logic tok_valid_o,
    output logic [3:0] tok_ep_o
);
    initial begin
        sof_o = '0;
        usb_reset_o = 1'b0;
        tok_valid_o = 1'b0;
        tok_ep_o = 4'h0;
    end
    // one-cycle report, then scrambled so stale values fail
    task automatic send_sof(input logic [10:0] frame, input logic bad);
        @(posedge clk_i);
        sof_o <= '{valid: 1'b1, crc_err: bad, frame: frame};
        @(posedge clk_i);
        sof_o <= '{valid: 1'b0, crc_err: ~bad, frame: ~frame};
    endtask
    // bus reset held three edges
    task automatic bus_reset();
        @(posedge clk_i);
        usb_reset_o <= 1'b1;
        repeat (3) @(posedge clk_i);
        usb_reset_o <= 1'b0;
    endtask
    // token; returns mid-cycle to sample settled outputs
    task automatic token(input logic [3:0] ep);
        @(posedge clk_i);
        tok_valid_o <= 1'b1;
        tok_ep_o <= ep;
        @(negedge clk_i);
    endtask
    task automatic token_off();
        @(posedge clk_i);
        tok_valid_o <= 1'b0;
        tok_ep_o <= ~tok_ep_o;
    endtask
endmodule

//--- testbench/tb_top.sv
`timescale 1ns/1ns
module tb_top;
    import usb_regs_pkg::*;
    logic clk_i = 1'b0;
    logic rst_b = 1'b0;
    logic [11:0] awaddr = 12'h000;
    logic [11:0] araddr = 12'h000;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, acc, ign, sof_ev, sof_irq, crc_o;
    logic usb_rst, tok_v;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata, mask_o, exp_mask, cw;
    logic [7:0] en_o, flush_o;
    logic [10:0] fcount;
    logic [3:0] tok_ep;
    sof_in_t sof;
    ep_cfg_t [7:0] cfg_o;
    int bad_count = 0;
    int tests_run = 0;
    always #25 clk_i = ~clk_i;
    usb_device_endpoint_config_regs dut (
        .clk_i(clk_i), .rst_b_i(rst_b), .s_awaddr_i(awaddr), .s_awvalid_i(awvalid),
        .s_awready_o(awready), .s_wdata_i(wdata), .s_wstrb_i(wstrb), .s_wvalid_i(wvalid),
        .s_wready_o(wready), .s_bresp_o(bresp), .s_bvalid_o(bvalid), .s_bready_i(bready),
        .s_araddr_i(araddr), .s_arvalid_i(arvalid), .s_arready_o(arready), .s_rdata_o(rdata),
        .s_rresp_o(rresp), .s_rvalid_o(rvalid), .s_rready_i(rready), .usb_reset_i(usb_rst),
        .sof_i(sof), .tok_valid_i(tok_v), .tok_ep_i(tok_ep), .tok_accept_o(acc),
        .tok_ignored_o(ign), .irq_enable_mask_o(mask_o), .endpoint_enable_o(en_o),
        .endpoint_flush_o(flush_o), .sof_event_o(sof_ev), .sof_irq_o(sof_irq),
        .frame_count_o(fcount), .frame_crc_error_o(crc_o), .endpoint_config_o(cfg_o));
    usb_host_model host (.clk_i(clk_i), .sof_o(sof), .usb_reset_o(usb_rst),
        .tok_valid_o(tok_v), .tok_ep_o(tok_ep));
    task automatic stop_test();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic hang();
        bad_count++;
        $display("CHECK FAILED handshake expected answer seen none");
        stop_test();
    endtask
    // ready sampled mid-cycle: it only moves at rising edges, so no race
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        logic at, wt, bt = 1'b0;
        logic [1:0] r;
        int n = 0;
        @(posedge clk_i);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hf;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!bt) begin
            if (n++ > 40) hang();
            @(negedge clk_i);
            at = awvalid && awready;
            wt = wvalid && wready;
            bt = bvalid;
            r = bresp;
            @(posedge clk_i);
            if (at) awvalid <= 1'b0;
            if (wt) wvalid <= 1'b0;
        end
        bready <= 1'b0;
        chk("bresp", 32'(er), 32'(r));
    endtask
    task automatic rchk(input string what, input logic [11:0] a, input logic [31:0] ed,
                        input logic [1:0] er);
        logic t, got = 1'b0;
        logic [31:0] d;
        logic [1:0] r;
        int n = 0;
        @(posedge clk_i);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!got) begin
            if (n++ > 40) hang();
            @(negedge clk_i);
            t = arvalid && arready;
            got = rvalid;
            d = rdata;
            r = rresp;
            @(posedge clk_i);
            if (t) arvalid <= 1'b0;
        end
        rready <= 1'b0;
        chk(what, ed, d);
        chk("rresp", 32'(er), 32'(r));
    endtask
    // tokens to every endpoint plus two beyond the last
    task automatic tok_sweep(input logic [15:0] en);
        for (int e = 0; e < 10; e++) begin
            host.token(4'(e));
            chk("accept", 32'(en[e]), 32'(acc));
            chk("ignored", 32'(!en[e]), 32'(ign));
        end
    endtask
    initial begin
        repeat (3) @(posedge clk_i);
        rst_b <= 1'b1;
        rchk("mask", OFF_IRQ_MASK, MASK_RESET, RESP_OKAY);
        rchk("enable", OFF_EP_ENABLE, 32'h0, RESP_OKAY);
        rchk("frame", OFF_FRAME_NUMBER, 32'h0, RESP_OKAY);
        for (int i = 0; i < NUM_EP; i++) begin
            rchk("config", OFF_EP_CONFIG + 12'(4 * i), 32'h0, RESP_OKAY);
        end
        rchk("clear reg", OFF_IRQ_EN_CLR, 32'h0, RESP_OKAY);
        rchk("unmapped", 12'h024, 32'h0, RESP_SLVERR);
        $display("test reset values done");
        exp_mask = MASK_RESET;
        for (int i = 0; i < 32; i++) begin
            wr(OFF_IRQ_EN_SET, 32'h1 << i, RESP_OKAY);
            exp_mask = exp_mask | ((32'h1 << i) & MASK_DEFINED);
            chk("mask set", exp_mask, mask_o);
        end
        for (int i = 0; i < 32; i += 3) begin
            wr(OFF_IRQ_EN_CLR, 32'h1 << i, RESP_OKAY);
            exp_mask = exp_mask & ~(32'h1 << i);
            chk("mask clear", exp_mask, mask_o);
        end
        wr(OFF_IRQ_EN_SET, 32'h0, RESP_OKAY);
        wr(OFF_IRQ_EN_CLR, 32'h0, RESP_OKAY);
        chk("mask zero write", exp_mask, mask_o);
        wr(OFF_IRQ_EN_SET, 32'h4, RESP_OKAY);
        wr(OFF_IRQ_EN_CLR, 32'h4, RESP_OKAY);
        exp_mask[MASK_SOF_BIT] = 1'b0;
        rchk("mask read", OFF_IRQ_MASK, exp_mask, RESP_OKAY);
        wr(OFF_IRQ_MASK, 32'h0, RESP_SLVERR);
        chk("mask read only", exp_mask, mask_o);
        $display("test mask done");
        wr(OFF_EP_ENABLE, 32'ha5, RESP_OKAY);
        rchk("enable", OFF_EP_ENABLE, 32'ha5, RESP_OKAY);
        tok_sweep(16'h00a5);
        cw = (32'h5 << REDIR_LSB) | (32'h2 << KIND_LSB) | (32'h1 << DIR_BIT);
        cw = cw | (32'h3 << SIZE_LSB) | (32'h1 << BANK_BIT);
        wr(OFF_EP_CONFIG + 12'h014, cw, RESP_OKAY);
        rchk("config", OFF_EP_CONFIG + 12'h014, cw, RESP_OKAY);
        // each of the four kinds written to endpoint 1 shows on its endpoint_kind output field
        for (int k = 0; k < 4; k++) begin
            wr(OFF_EP_CONFIG + 12'h004, 32'(k) << KIND_LSB, RESP_OKAY);
            chk("kind", 32'(k), 32'(cfg_o[1].endpoint_kind));
        end
        wr(OFF_EP_ENABLE, 32'h85, RESP_OKAY);
        rchk("enable off", OFF_EP_ENABLE, 32'h85, RESP_OKAY);
        rchk("config kept", OFF_EP_CONFIG + 12'h014, cw & ~(32'hf << REDIR_LSB), RESP_OKAY);
        tok_sweep(16'h0085);
        host.token_off();
        $display("test endpoints done");
        wr(OFF_IRQ_EN_SET, 32'h4, RESP_OKAY);
        exp_mask[MASK_SOF_BIT] = 1'b1;
        host.send_sof(11'h7ff, 1'b0);
        rchk("frame", OFF_FRAME_NUMBER, 32'h7ff << FRAME_COUNT_FIELD_LSB, RESP_OKAY);
        host.send_sof(11'h123, 1'b1);
        cw = (32'h123 << FRAME_COUNT_FIELD_LSB) | (32'h1 << FRAME_CRC_ERROR_FLAG_BIT);
        rchk("frame bad", OFF_FRAME_NUMBER, cw, RESP_OKAY);
        host.bus_reset();
        rchk("frame reset", OFF_FRAME_NUMBER, 32'h0, RESP_OKAY);
        rchk("config reset", OFF_EP_CONFIG + 12'h014, 32'h0, RESP_OKAY);
        chk("mask kept", exp_mask, mask_o);
        $display("test frames done");
        stop_test();
    end
endmodule
